// file: hw/seq_pkg.sv
// Constants, types and register map shared by the speed-program sequencer files.
// Operation
// R1 - Retain mode 0: any stop discards position; next start begins at segment one.
// R2 - Retain mode 1: a stop keeps segment and progress; restart continues from there. A stop in hold-last drops back to segment one.
// R3 - Reset at power-up clears retained position; program restarts from its initial state.
// R4 - Program enable 0 keeps sequencer idle; enable 1 lets the program drive output.
// R5 - Source priority: jog, external, internal program, PID, triangle, winding, normal.
// R6 - Run mode 0..4: one-shot, pause one-shot, cycle, pause cycle, hold last.
// R7 - Run mode matters only while the program is enabled and started.
// R8 - Pause style ramps to standstill after each segment before the next one.
// R9 - Fifteen segment frequencies, zero to maximum, in 0.01 Hz steps.
// R10 - Frequency defaults 10.0 to 50.0 by 5.0 for one to nine, then 10.0.
// R11 - Per-segment durations up to 999.9 s; defaults 100 s for one to five, else 0.
// R12 - Direction word gives one bit per segment: 0 forward, 1 reverse, only when enabled.
// R13 - Direction bit 0 steers the main frequency; bit n steers segment n.
// R14 - Segment time counts fixed ticks of the clock; reaching duration advances the segment.
package seq_pkg;

	// Widths of the stored settings.
	localparam int SEG_COUNT = 15;
	localparam int FREQ_W = 16;
	localparam int DUR_W = 14;
	localparam int ADDR_W = 12;
	localparam logic [3:0] SEG_LAST = 4'hE;
	localparam logic [DUR_W-1:0] DUR_MAX = 14'h270F;

	// Clock and segment tick timing, the tick being one duration unit of 0.1 s.
	localparam longint CLK_PERIOD_PS = 25000;
	localparam longint TICK_TIME_PS = 100000000000;
	localparam int unsigned TICK_CYCLES_DEF = int'(TICK_TIME_PS / CLK_PERIOD_PS);
	localparam int PRESCALE_W = 22;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_COMMAND = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_FREQ_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] ADDR_DUR_BASE = 12'h080;

	// Decoded register selectors.
	localparam logic [5:0] SEL_CONFIG = 6'h00;
	localparam logic [5:0] SEL_COMMAND = 6'h01;
	localparam logic [5:0] SEL_DIRECTION = 6'h02;
	localparam logic [5:0] SEL_STATUS = 6'h03;
	localparam logic [1:0] SEL_FREQ = 2'h1;
	localparam logic [1:0] SEL_DUR = 2'h2;
	localparam logic [5:0] SEL_NONE = 6'h3F;

	// Field positions.
	localparam int CFG_RETAIN_BIT = 0;
	localparam int CFG_ENABLE_BIT = 1;
	localparam int CFG_MODE_LSB = 2;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_SEG_LSB = 4;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_LEVEL_LSB = 12;

	// Run modes.
	localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
	localparam logic [2:0] MODE_PAUSE_ONE = 3'h1;
	localparam logic [2:0] MODE_CYCLE = 3'h2;
	localparam logic [2:0] MODE_PAUSE_CYCLE = 3'h3;
	localparam logic [2:0] MODE_HOLD_LAST = 3'h4;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Source priority levels, one being the highest.
	localparam logic [2:0] LEVEL_PROGRAM = 3'h3;
	localparam logic [2:0] LEVEL_NORMAL = 3'h7;

	// Power-up settings, segment one in the lowest slot.
	localparam logic [SEG_COUNT-1:0][FREQ_W-1:0] FREQ_DEFAULT = {
		16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h1388,
		16'h1194, 16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC, 16'h03E8};
	localparam logic [SEG_COUNT-1:0][DUR_W-1:0] DUR_DEFAULT = {
		14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
		14'h0000, 14'h0000, 14'h0000, 14'h03E8, 14'h03E8, 14'h03E8, 14'h03E8, 14'h03E8};

	typedef enum logic [2:0] {SEQ_IDLE, SEQ_RUN, SEQ_PAUSE, SEQ_HOLD, SEQ_PARKED} seq_state_e;

	// Maps a byte address to a register selector; misaligned or unused gives none.
	function automatic logic [5:0] reg_decode(input logic [ADDR_W-1:0] a);
		logic [5:0] sel;
		sel = SEL_NONE;
		if (a[1:0] == 2'h0) begin
			if (a[ADDR_W-1:4] == ADDR_CONFIG[ADDR_W-1:4]) begin
				sel = {4'h0, a[3:2]};
			end else if (a[ADDR_W-1:6] == ADDR_FREQ_BASE[ADDR_W-1:6] && a[5:2] != 4'hF) begin
				sel = {SEL_FREQ, a[5:2]};
			end else if (a[ADDR_W-1:6] == ADDR_DUR_BASE[ADDR_W-1:6] && a[5:2] != 4'hF) begin
				sel = {SEL_DUR, a[5:2]};
			end
		end
		return sel;
	endfunction : reg_decode

	// Merges the two low byte lanes of a write into a 16-bit setting.
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : lane16

endpackage : seq_pkg

// file: hw/seq_timer_if.sv
// Interface between the sequencer control and its segment timer.
`timescale 1ns/1ps
`default_nettype none
interface seq_timer_if;
	import seq_pkg::*;
	logic clear;
	logic run;
	logic [DUR_W-1:0] limit;
	logic done;
	logic [DUR_W-1:0] elapsed;
	modport ctrl(output clear, output run, output limit, input done, input elapsed);
	modport timer(input clear, input run, input limit, output done, output elapsed);
endinterface : seq_timer_if
`default_nettype wire

// file: hw/segment_timer.sv
// Segment timer: counts 0.1 s ticks of elapsed segment time.
`timescale 1ns/1ps
`default_nettype none
module segment_timer
	import seq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control side.
	seq_timer_if.timer tmr
);

	typedef struct packed {
		logic [PRESCALE_W-1:0] pre;
		logic [DUR_W-1:0] elapsed;
	} timer_s;

	timer_s state_q;
	timer_s state_d;

	// The prescaler makes a tick; elapsed counts ticks and freezes once the limit is met.
	always_comb begin
		state_d = state_q;
		if (!aresetn || tmr.clear) begin
			state_d = '0;
		end else if (tmr.run && !tmr.done) begin
			if (state_q.pre == PRESCALE_W'(TICK_CYCLES - 1)) begin // see R14
				state_d.pre = '0;
				state_d.elapsed = state_q.elapsed + 1'b1;
			end else begin
				state_d.pre = state_q.pre + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		state_q <= state_d;
	end

	// Done compares against the live limit so a zero duration ends at once.
	assign tmr.done = state_q.elapsed >= tmr.limit; // see R11
	assign tmr.elapsed = state_q.elapsed;

endmodule : segment_timer
`default_nettype wire

// file: hw/speed_sequencer.sv
// Speed-program sequencer with source priority and an AXI4-Lite register slave.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module speed_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Run commands and drive feedback.
	input wire logic run_start,
	input wire logic run_stop,
	input wire logic fault_stop,
	input wire logic ramp_at_zero,
	// Other frequency sources, slots for levels 1, 2, 4, 5 and 6.
	input wire logic [4:0] other_valid,
	input wire logic [4:0][FREQ_W-1:0] other_freq,
	input wire logic [4:0] other_reverse,
	input wire logic [FREQ_W-1:0] normal_freq,
	input wire logic normal_reverse,
	// Command to the ramp logic.
	output logic [FREQ_W-1:0] freq_cmd,
	output logic reverse_cmd,
	output logic [2:0] source_level,
	output logic seq_active,
	output logic [3:0] segment_index
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic retain;
		logic enable;
		logic [2:0] run_mode;
		logic [15:0] dir_word;
		logic cmd_start;
		logic cmd_stop;
		logic [SEG_COUNT-1:0][FREQ_W-1:0] freq;
		logic [SEG_COUNT-1:0][DUR_W-1:0] dur;
		seq_state_e state;
		logic [3:0] seg;
		logic [3:0] shown;
		logic active;
		logic [FREQ_W-1:0] freq_cmd;
		logic reverse;
		logic [2:0] level;
	} seq_s;

	// All state lives in one register; the next-state process fills its copy.
	seq_s state_q;
	seq_s state_d;

	// The timer keeps its own prescaler, so this block only sees whole ticks.
	seq_timer_if tmr_bus();

	// Decodes of the registered state and the pins, shared below.
	logic timer_clear;
	logic wr_fire;
	logic go;
	logic halt;
	logic last_seg;
	logic pause_style;
	logic [2:0] mode;
	logic [5:0] wsel;
	logic [5:0] rsel;
	logic [6:0] all_valid;
	logic [6:0][FREQ_W-1:0] all_freq;
	logic [6:0] all_reverse;

	segment_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.tmr(tmr_bus.timer)
	);

	// The timer runs only in a live segment, so parked progress is frozen in place.
	assign tmr_bus.clear = timer_clear;
	assign tmr_bus.run = state_q.enable && state_q.state == SEQ_RUN; // see R2
	assign tmr_bus.limit = state_q.dur[state_q.seg];

	// Commands from pins and from the command register are merged; stop wins over start.
	assign go = run_start || state_q.cmd_start;
	assign halt = run_stop || fault_stop || state_q.cmd_stop;
	assign last_seg = state_q.seg == SEG_LAST;
	// Out-of-range mode codes behave as one-shot.
	assign mode = (state_q.run_mode > MODE_HOLD_LAST) ? MODE_ONE_SHOT : state_q.run_mode; // see R6
	assign pause_style = mode == MODE_PAUSE_ONE || mode == MODE_PAUSE_CYCLE; // see R8
	assign wsel = reg_decode(state_q.aw_addr);
	assign rsel = reg_decode(s_axi_araddr);

	// Candidate sources by priority slot; the program claims its slot only while live.
	assign all_valid = {1'b1, other_valid[4:2], state_q.active, other_valid[1:0]}; // see R5
	assign all_freq = {normal_freq, other_freq[4:2],
		(state_q.state == SEQ_PAUSE) ? {FREQ_W{1'b0}} : state_q.freq[state_q.shown],
		other_freq[1:0]};
	// Bit 0 steers the main frequency only while the program is enabled.
	assign all_reverse = {state_q.enable ? state_q.dir_word[0] : normal_reverse, // see R13
		other_reverse[4:2], state_q.dir_word[state_q.shown + 4'h1], other_reverse[1:0]}; // see R12

	// Bus slave, program stepping and output selection in one next-state process.
	always_comb begin
		state_d = state_q;
		timer_clear = 1'b0;
		state_d.cmd_start = 1'b0;
		state_d.cmd_stop = 1'b0;

		// Address and data are latched independently, in either order.
		if (s_axi_awvalid && state_q.awready) begin
			state_d.aw_have = 1'b1;
			state_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_q.wready) begin
			state_d.w_have = 1'b1;
			state_d.w_data = s_axi_wdata;
			state_d.w_strb = s_axi_wstrb;
		end
		// The response leaves on its own handshake; no write fires meanwhile.
		if (state_q.bvalid && s_axi_bready) begin
			state_d.bvalid = 1'b0;
		end
		wr_fire = state_q.aw_have && state_q.w_have && !state_q.bvalid;
		if (wr_fire) begin
			state_d.aw_have = 1'b0;
			state_d.w_have = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = RESP_OKAY;
			if (wsel == SEL_CONFIG) begin
				if (state_q.w_strb[0]) begin
					state_d.retain = state_q.w_data[CFG_RETAIN_BIT];
					state_d.enable = state_q.w_data[CFG_ENABLE_BIT];
					state_d.run_mode = state_q.w_data[CFG_MODE_LSB +: 3];
				end
			end else if (wsel == SEL_COMMAND) begin
				if (state_q.w_strb[0]) begin
					state_d.cmd_start = state_q.w_data[CMD_START_BIT];
					state_d.cmd_stop = state_q.w_data[CMD_STOP_BIT];
				end
			end else if (wsel == SEL_DIRECTION) begin
				state_d.dir_word = lane16(state_q.dir_word, state_q.w_data, state_q.w_strb);
			end else if (wsel[5:4] == SEL_FREQ) begin
				state_d.freq[wsel[3:0]] = lane16(state_q.freq[wsel[3:0]], state_q.w_data,
					state_q.w_strb); // see R9
			end else if (wsel[5:4] == SEL_DUR) begin
				state_d.dur[wsel[3:0]] = DUR_W'(lane16({2'h0, state_q.dur[wsel[3:0]]},
					state_q.w_data, state_q.w_strb));
				if (state_d.dur[wsel[3:0]] > DUR_MAX) begin
					state_d.dur[wsel[3:0]] = DUR_MAX; // see R11
				end
			end else if (wsel != SEL_STATUS) begin
				state_d.bresp = RESP_SLVERR;
			end
		end
		// Ready follows the next state, so a new write waits for the response.
		state_d.awready = !state_d.aw_have && !state_d.bvalid;
		state_d.wready = !state_d.w_have && !state_d.bvalid;

		// Reads answer one cycle after the address is taken.
		if (state_q.rvalid && s_axi_rready) begin
			state_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && state_q.arready) begin
			state_d.rvalid = 1'b1;
			state_d.rresp = RESP_OKAY;
			state_d.rdata = '0;
			if (rsel == SEL_CONFIG) begin
				state_d.rdata[CFG_RETAIN_BIT] = state_q.retain;
				state_d.rdata[CFG_ENABLE_BIT] = state_q.enable;
				state_d.rdata[CFG_MODE_LSB +: 3] = state_q.run_mode;
			end else if (rsel == SEL_DIRECTION) begin
				state_d.rdata[15:0] = state_q.dir_word;
			end else if (rsel == SEL_STATUS) begin
				state_d.rdata[ST_ACTIVE_BIT] = state_q.active;
				state_d.rdata[ST_SEG_LSB +: 4] = state_q.seg;
				state_d.rdata[ST_STATE_LSB +: 3] = state_q.state;
				state_d.rdata[ST_LEVEL_LSB +: 3] = state_q.level;
			end else if (rsel[5:4] == SEL_FREQ) begin
				state_d.rdata[FREQ_W-1:0] = state_q.freq[rsel[3:0]];
			end else if (rsel[5:4] == SEL_DUR) begin
				state_d.rdata[DUR_W-1:0] = state_q.dur[rsel[3:0]];
			end else if (rsel != SEL_COMMAND) begin
				state_d.rresp = RESP_SLVERR;
			end
		end
		// Only one read is outstanding; the address stays shut while data waits.
		state_d.arready = !state_d.rvalid;

		// Program stepping; run mode is only consulted from a live segment.
		if (!state_q.enable) begin
			state_d.state = SEQ_IDLE; // see R4
			state_d.seg = 4'h0;
			timer_clear = 1'b1;
		end else begin
			unique case (state_q.state)
				SEQ_IDLE, SEQ_PARKED: begin
					if (go && !halt) begin
						state_d.state = SEQ_RUN;
						if (state_q.state == SEQ_IDLE || !state_q.retain) begin
							state_d.seg = 4'h0; // see R1
							timer_clear = 1'b1;
						end
					end
				end
				SEQ_RUN: begin
					if (halt) begin
						state_d.state = state_q.retain ? SEQ_PARKED : SEQ_IDLE; // see R2
						if (!state_q.retain) begin
							state_d.seg = 4'h0; // see R1
							timer_clear = 1'b1;
						end
					end else begin
						// A zero-duration segment passes without changing the shown frequency.
						if (state_q.dur[state_q.seg] != '0) begin
							state_d.shown = state_q.seg;
						end
						if (tmr_bus.done) begin // see R14
							timer_clear = 1'b1;
							if (pause_style && state_q.dur[state_q.seg] != '0
									&& !(last_seg && mode == MODE_PAUSE_ONE)) begin
								state_d.state = SEQ_PAUSE; // see R8
							end else if (!last_seg) begin
								state_d.seg = state_q.seg + 4'h1;
							end else if (mode == MODE_CYCLE || mode == MODE_PAUSE_CYCLE) begin
								state_d.seg = 4'h0; // see R7
							end else if (mode == MODE_HOLD_LAST) begin
								state_d.state = SEQ_HOLD; // see R6
							end else begin
								state_d.state = SEQ_IDLE;
								state_d.seg = 4'h0;
							end
						end
					end
				end
				SEQ_PAUSE: begin
					if (halt) begin
						state_d.state = state_q.retain ? SEQ_PARKED : SEQ_IDLE;
						if (!state_q.retain) begin
							state_d.seg = 4'h0;
						end
					end else if (ramp_at_zero) begin
						// The next segment starts only after the drive reports standstill.
						state_d.state = SEQ_RUN; // see R8
						state_d.seg = last_seg ? 4'h0 : state_q.seg + 4'h1;
						timer_clear = 1'b1;
					end
				end
				SEQ_HOLD: begin
					// Leaving hold always drops the position, even with retention.
					if (halt) begin
						state_d.state = SEQ_IDLE;
						state_d.seg = 4'h0;
					end
				end
			endcase
		end
		// An idle program shows segment one again, ready for the next start.
		if (state_d.state == SEQ_IDLE) begin
			state_d.shown = 4'h0;
		end
		// Active lags the state by one cycle, unlike segment_index, which changes in the same cycle as the state.
		state_d.active = state_q.enable && (state_q.state == SEQ_RUN
			|| state_q.state == SEQ_PAUSE || state_q.state == SEQ_HOLD);

		// Highest-priority valid source wins; normal setting is always available.
		state_d.level = LEVEL_NORMAL;
		state_d.freq_cmd = all_freq[6];
		state_d.reverse = all_reverse[6];
		for (int i = 5; i >= 0; i--) begin
			if (all_valid[i]) begin
				state_d.level = 3'(i + 1); // see R5
				state_d.freq_cmd = all_freq[i];
				state_d.reverse = all_reverse[i];
			end
		end

		// Power-up clears every retained position and restores the default program.
		if (!aresetn) begin
			state_d = '0; // see R3
			state_d.freq = FREQ_DEFAULT; // see R10
			state_d.dur = DUR_DEFAULT; // see R11
			state_d.state = SEQ_IDLE;
			state_d.level = LEVEL_NORMAL;
			timer_clear = 1'b1;
		end
	end

	// Reset is handled in the process above, so the register has no reset branch.
	always_ff @(posedge aclk) begin
		state_q <= state_d;
	end

	// Every output is a field of the registered state.
	assign s_axi_awready = state_q.awready;
	assign s_axi_wready = state_q.wready;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_arready = state_q.arready;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
	assign s_axi_rvalid = state_q.rvalid;
	assign freq_cmd = state_q.freq_cmd;
	assign reverse_cmd = state_q.reverse;
	assign source_level = state_q.level;
	assign seq_active = state_q.active;
	assign segment_index = state_q.seg;

endmodule : speed_sequencer
`default_nettype wire

// file: verification/ramp_model.sv
// Behavioural model of the drive ramp that follows the sequencer's frequency command.
`timescale 1ns/1ps
`default_nettype none
module ramp_model #(
	parameter logic [15:0] STEP = 16'h0200
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Command in, standstill report out.
	input wire logic [15:0] freq_cmd,
	output logic ramp_at_zero
);
	logic [15:0] out_q;

	// A finite slew makes the standstill report arrive late, as a real ramp would.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= 16'h0000;
		end else if (out_q > freq_cmd) begin
			out_q <= (out_q - freq_cmd > STEP) ? out_q - STEP : freq_cmd;
		end else begin
			out_q <= (freq_cmd - out_q > STEP) ? out_q + STEP : freq_cmd;
		end
	end

	// Standstill is reported only once the output has truly reached zero.
	assign ramp_at_zero = (out_q == 16'h0000);
endmodule : ramp_model
`default_nettype wire

// file: verification/seq_check_sva.sv
// Checker for the sequencer top: bus handshakes, source priority and run control.
`timescale 1ns/1ps
`default_nettype none
module seq_check
	import seq_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Run control and outputs.
	input wire logic run_stop,
	input wire logic fault_stop,
	input wire logic [4:0] other_valid,
	input wire logic [2:0] source_level,
	input wire logic seq_active,
	input wire logic [3:0] segment_index
);
	// All checks share the one clock; reset silences them.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_busy_quiet: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_stop_ends_run: assert property ((run_stop || fault_stop) && seq_active |->
		##[1:3] !seq_active) else $error("stop did not end the program");
	a_jog_wins: assert property (other_valid[0] |-> ##[1:2] source_level == 3'h1)
		else $error("jog not selected");
	a_program_active: assert property (source_level == 3'h3 |-> $past(seq_active))
		else $error("program level while inactive");
	a_segment_range: assert property (segment_index <= 4'hE)
		else $error("segment index beyond fifteen");
endmodule : seq_check
bind speed_sequencer seq_check #(.TICK_CYCLES(TICK_CYCLES)) checker_i (.*);
`default_nettype wire

// file: verification/tb_multi_segment_speed_sequencer.sv
// Self-checking bench for the speed-program sequencer with a ramp model.
`timescale 1ns/1ps
`default_nettype none
module tb_multi_segment_speed_sequencer;
	import seq_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] w; bit wr; logic [31:0] r; logic [1:0] resp;} row_s;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic run_start, run_stop, fault_stop, ramp_at_zero, normal_reverse, reverse_cmd, seq_active;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, segment_index;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [4:0] other_valid, other_reverse;
	logic [4:0][FREQ_W-1:0] other_freq;
	logic [FREQ_W-1:0] normal_freq, freq_cmd;
	logic [2:0] source_level;
	int miscompares, comparisons;
	// Register cases: address, write data, write flag, read value, response.
	row_s rows[10] = '{'{12'h040, 0, 0, 32'h03E8, 0},
		'{12'h060, 0, 0, 32'h1388, 0}, '{12'h064, 0, 0, 32'h03E8, 0},
		'{12'h090, 0, 0, 32'h03E8, 0}, '{12'h094, 0, 0, 32'h0000, 0},
		'{12'h000, 0, 0, 32'h0000, 0}, '{12'h008, 32'hFFFF, 1, 32'hFFFF, 0},
		'{12'h078, 32'hFFFF, 1, 32'hFFFF, 0}, '{12'h0B8, 32'h3FFF, 1, 32'h270F, 0},
		'{12'h07C, 32'h1, 1, 32'h0, 2'h2}};

	speed_sequencer #(.TICK_CYCLES(4)) dut (.*);
	ramp_model far (.aclk(aclk), .aresetn(aresetn), .freq_cmd(freq_cmd), .ramp_at_zero(ramp_at_zero));

	// Forty megahertz clock.
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Write with bready raised late, so the slave must hold its response.
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Pulses start, stop and fault pins for one clock.
	task automatic pins(input logic [2:0] v);
		@(posedge aclk);
		{run_start, run_stop, fault_stop} <= v;
		@(posedge aclk);
		{run_start, run_stop, fault_stop} <= 3'h0;
	endtask : pins

	// Raises each other source alone; levels below base must win.
	task automatic prio(input logic [2:0] base, input logic [15:0] pf);
		logic [2:0] lv;
		for (int i = 0; i < 5; i++) begin
			lv = (i < 2) ? 3'(i + 1) : 3'(i + 2);
			@(posedge aclk);
			other_valid <= 5'(1 << i);
			tick(3);
			chk(source_level, (lv < base) ? lv : base);
			chk(freq_cmd, (lv < base) ? other_freq[i] : pf);
		end
		@(posedge aclk);
		other_valid <= 5'h00;
		tick(3);
	endtask : prio

	task automatic run_mode(input logic [2:0] m);
		int cnt;
		logic z;
		wr(ADDR_CONFIG, {27'h0, m, 2'b10}, rs);
		pins(3'b100);
		tick(3);
		chk(freq_cmd, 16'h07D0);
		chk(reverse_cmd, 1'b0);
		z = 1'b0;
		cnt = 0;
		for (int n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (seq_active === 1'b1 && freq_cmd === 16'h0000) z = 1'b1;
			if (segment_index === 4'h1) cnt++;
		end
		if (m == 3'h0 || m == 3'h5) chk(cnt, 13);
		chk(z, m == 3'h1 || m == 3'h3);
		chk(seq_active, m >= 3'h2 && m <= 3'h4);
		if (m == 3'h4) begin
			chk(freq_cmd, 16'h0BB8);
			chk(reverse_cmd, 1'b1);
			prio(3'h3, 16'h0BB8);
		end
		pins(3'b010);
		tick(3);
		chk(seq_active, 1'b0);
		chk(reverse_cmd, 1'b0);
		$display("mode %0d done", m);
	endtask : run_mode

	// Faults in segment two, then restarts through the command register.
	task automatic retain(input logic r);
		wr(ADDR_CONFIG, {30'h0, 1'b1, r}, rs);
		pins(3'b100);
		for (int n = 0; n < 50 && segment_index !== 4'h1; n++) @(posedge aclk);
		pins(3'b001);
		tick(3);
		chk(seq_active, 1'b0);
		wr(ADDR_COMMAND, 32'h1, rs);
		tick(4);
		chk(segment_index, {3'h0, r});
		pins(3'b010);
		tick(3);
		$display("retain %0d done", r);
	endtask : retain

	task automatic conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// Every test together needs well under this many clocks.
	initial begin
		tick(30000);
		miscompares++;
		conclude;
	end

	// Main sequence.
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{run_start, run_stop, fault_stop} = 3'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		other_valid = 5'h00;
		other_reverse = 5'h0A;
		other_freq = {16'h1005, 16'h1004, 16'h1003, 16'h1002, 16'h1001};
		normal_freq = 16'h0123;
		normal_reverse = 1'b1;
		tick(16);
		aresetn <= 1'b1;
		tick(3);
		chk(source_level, 3'h7);
		chk(freq_cmd, 16'h0123);
		chk(reverse_cmd, 1'b1);
		pins(3'b100);
		tick(3);
		chk(seq_active, 1'b0);
		prio(3'h7, 16'h0123);
		$display("reset and idle done");
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].w, rs);
			if (rows[i].wr) chk(rs, rows[i].resp);
			rd(rows[i].a, d, rs);
			chk(d, rows[i].r);
			chk(rs, rows[i].resp);
		end
		$display("registers done");
		// Short program: segment one 0.2 s, segment two 0.3 s reversed, three to fifteen skipped.
		wr(12'h080, 32'h2, rs);
		wr(12'h084, 32'h3, rs);
		for (int k = 0; k < 3; k++) wr(12'(12'h088 + 4 * k), 32'h0, rs);
		wr(12'h0B8, 32'h0, rs);
		wr(12'h040, 32'h07D0, rs);
		wr(12'h044, 32'h0BB8, rs);
		wr(ADDR_DIRECTION, 32'h4, rs);
		for (int m = 0; m < 6; m++) run_mode(3'(m));
		retain(1'b0);
		retain(1'b1);
		// A power cycle must forget the parked position and the settings.
		aresetn <= 1'b0;
		tick(16);
		aresetn <= 1'b1;
		tick(3);
		chk(segment_index, 4'h0);
		rd(ADDR_CONFIG, d, rs);
		chk(d, 32'h0);
		wr(ADDR_CONFIG, 32'h3, rs);
		pins(3'b100);
		tick(4);
		chk(segment_index, 4'h0);
		chk(freq_cmd, 16'h03E8);
		pins(3'b010);
		$display("power cycle done");
		conclude;
	end
endmodule : tb_multi_segment_speed_sequencer
`default_nettype wire
